// *** hdl/qry_host_pkg.sv ***
/*
 * Shared types and constants for the query-table host controller:
 * pin bundle, query command code, timing counts and the controller state.
 * Assumes a 200 MHz clock and a parallel flash with 16-bit data bus.
 */
package qry_host_pkg;

    // Clock period in ns
    localparam int CLK_NS    = 5;
    // Strobe timings in ns
    localparam int T_WP_NS   = 35;      // Write-enable low width
    localparam int T_ACC_NS  = 70;      // Read access time
    localparam int T_REC_NS  = 20;      // Recovery between bus cycles

    // Cycle counts, least times rounded up
    localparam logic [4:0] WP_CYC  = 5'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0] ACC_CYC = 5'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0] REC_CYC = 5'((T_REC_NS + CLK_NS - 1) / CLK_NS);

    // Address and data widths
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;

    // Query command and its addresses
    localparam logic [7:0]        QUERY_CODE     = 8'h98;
    localparam logic [ADDR_W-1:0] QRY_ADDR_WORD  = 22'h000055;
    localparam logic [ADDR_W-1:0] QRY_ADDR_BYTE  = 22'h0000AA;
    localparam logic [ADDR_W-1:0] RST_ADDR       = 22'h000000;

    // User-side operations
    typedef enum logic [1:0] {
        OP_ENTER,
        OP_EXIT,
        OP_READ
    } op_t;

    // Device mode as tracked by the host
    typedef enum logic [1:0] {
        MODE_ARRAY,
        MODE_ID,
        MODE_QRY_ARR,
        MODE_QRY_ID
    } mode_t;

    // Bus cycle phases
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_SETUP,
        PH_STROBE,
        PH_HOLD,
        PH_READ,
        PH_REC
    } phase_t;

    // Control pins toward the flash
    typedef struct packed {
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
        logic [ADDR_W-1:0] addr;
    } flash_pins_t;

    // Whole controller state
    typedef struct packed {
        phase_t            phase;
        logic [4:0]        cnt;
        op_t               op;
        mode_t             mode;
        logic              from_id;
        logic              byte_mode;
        logic [7:0]        idx;
        flash_pins_t       pins;
        logic [DATA_W-1:0] dq_data;
        logic              dq_oe;
        logic [DATA_W-1:0] rdata;
        logic              ready;
        logic              done;
        logic              refused;
        logic              match;
    } state_t;

    // State after reset: all strobes high, bus released
    localparam state_t ST_RESET = '{
        phase:     PH_IDLE,
        cnt:       5'h00,
        op:        OP_READ,
        mode:      MODE_ARRAY,
        from_id:   1'b0,
        byte_mode: 1'b0,
        idx:       8'h00,
        pins:      '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 22'h000000},
        dq_data:   16'h0000,
        dq_oe:     1'b0,
        rdata:     16'h0000,
        ready:     1'b1,
        done:      1'b0,
        refused:   1'b0,
        match:     1'b0
    };

endpackage

// *** hdl/query_table_rom.sv ***
/*
 * Expected descriptor words of the query table, indexed by word address.
 * Purely combinational; the caller registers whatever it compares.
 */
`timescale 1ns/100ps
module query_table_rom (
    // Word address into the table
    input  wire logic [7:0]  index_in,
    // Expected descriptor word
    output logic      [15:0] word_out
);

    // Listed entries; anything else, and every upper byte, reads zero
    always_comb begin
        case (index_in)
            8'h10:   word_out = 16'h0051;   // Signature Q
            8'h11:   word_out = 16'h0052;   // Signature R
            8'h12:   word_out = 16'h0059;   // Signature Y
            8'h13:   word_out = 16'h0002;   // Command set
            8'h15:   word_out = 16'h0040;   // Extended table pointer
            8'h1B:   word_out = 16'h0027;   // Supply min
            8'h1C:   word_out = 16'h0036;   // Supply max
            8'h1F:   word_out = 16'h0004;   // Word write typical
            8'h21:   word_out = 16'h000A;   // Block erase typical
            8'h23:   word_out = 16'h0005;   // Word write max
            8'h25:   word_out = 16'h0004;   // Block erase max
            8'h27:   word_out = 16'h0016;   // Size exponent
            8'h28:   word_out = 16'h0002;   // Interface code
            8'h2C:   word_out = 16'h0002;   // Region count
            8'h2D:   word_out = 16'h0007;   // Region 1
            8'h2F:   word_out = 16'h0020;   // Region 1
            8'h31:   word_out = 16'h003E;   // Region 2
            8'h34:   word_out = 16'h0001;   // Region 2
            // Zero entries
            default: word_out = 16'h0000;
        endcase
    end

endmodule // query_table_rom

// *** hdl/qry_host.sv ***
/*
 * Host controller that puts a parallel flash into query-table mode,
 * reads descriptor words, checks them, and leaves the mode again.
 * Assumes the flash pins are synchronous to clk_in, a ready level from
 * the flash, and a level telling whether the device sits in ID mode.
 */
`timescale 1ns/100ps
module qry_host #(
    parameter logic [7:0] RESET_CODE = 8'hF0    // Reset command data
) (
    // Clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        nrst_in,
    // User command port
    input  wire logic                        cmd_valid_in,
    input  wire qry_host_pkg::op_t           cmd_op_in,
    input  wire logic [7:0]                  index_in,
    input  wire logic                        byte_mode_in,
    input  wire logic                        id_mode_in,
    // User answer port
    output logic                             ready_out,
    output logic                             done_out,
    output logic                             refused_out,
    output logic [qry_host_pkg::DATA_W-1:0]  rdata_out,
    output logic                             match_out,
    output qry_host_pkg::mode_t              mode_out,
    // Flash pins
    input  wire logic                        dev_ready_in,
    input  wire logic [qry_host_pkg::DATA_W-1:0] dq_in,
    output qry_host_pkg::flash_pins_t        pins_out,
    output logic [qry_host_pkg::DATA_W-1:0]  dq_data_out,
    output logic                             dq_oe_out
);
    import qry_host_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State and helpers

    state_t            st_reg;      // Registered state
    state_t            st_next;     // Next state
    logic              query_now;   // Device believed in query mode
    logic [15:0]       expect_word; // Table word for current index

    assign query_now = (st_reg.mode == MODE_QRY_ARR) || (st_reg.mode == MODE_QRY_ID);

    // Reference table for read checks
    query_table_rom u_rom (
        .index_in (st_reg.idx),
        .word_out (expect_word)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    // One bus cycle at a time; strobes never overlap
    always_comb begin
        st_next         = st_reg;
        st_next.done    = 1'b0;
        st_next.refused = 1'b0;
        case (st_reg.phase)
            PH_IDLE: begin
                // Mode outside query follows the ID level
                if (!query_now) begin
                    st_next.mode = id_mode_in ? MODE_ID : MODE_ARRAY;
                end
                if (cmd_valid_in) begin
                    if (cmd_op_in == OP_ENTER && (!dev_ready_in || query_now)) begin
                        // Busy bank or already inside
                        st_next.refused = 1'b1;
                    end else if (cmd_op_in == OP_READ && !query_now) begin
                        // Table reads only make sense in query mode
                        st_next.refused = 1'b1;
                    end else begin
                        st_next.op        = cmd_op_in;
                        st_next.byte_mode = byte_mode_in;
                        st_next.idx       = index_in;
                        st_next.from_id   = id_mode_in;
                        st_next.cnt       = 5'h00;
                        st_next.phase     = PH_SETUP;
                        st_next.pins.ce_n = 1'b0;
                        case (cmd_op_in)
                            OP_ENTER: begin
                                // Query address by bus width
                                st_next.pins.addr = byte_mode_in ? QRY_ADDR_BYTE
                                                                 : QRY_ADDR_WORD;
                                st_next.dq_data   = {8'h00, QUERY_CODE};
                                st_next.dq_oe     = 1'b1;
                            end
                            OP_EXIT: begin
                                // Address is a don't-care
                                st_next.pins.addr = RST_ADDR;
                                st_next.dq_data   = {8'h00, RESET_CODE};
                                st_next.dq_oe     = 1'b1;
                            end
                            default: begin
                                // Byte address is twice the word
                                st_next.pins.addr = byte_mode_in
                                    ? {13'h0000, index_in, 1'b0}
                                    : {14'h0000, index_in};
                                st_next.dq_oe     = 1'b0;
                            end
                        endcase
                    end
                end
            end
            PH_SETUP: begin
                // Address stable before the strobe falls
                if (st_reg.op == OP_READ) begin
                    st_next.pins.oe_n = 1'b0;
                    st_next.phase     = PH_READ;
                end else begin
                    st_next.pins.we_n = 1'b0;
                    st_next.phase     = PH_STROBE;
                end
            end
            PH_STROBE: begin
                // Hold write-enable low its full width
                if (st_reg.cnt == WP_CYC - 5'h01) begin
                    st_next.pins.we_n = 1'b1;
                    st_next.phase     = PH_HOLD;
                end else begin
                    st_next.cnt = st_reg.cnt + 5'h01;
                end
            end
            PH_HOLD: begin
                // Data still driven past the rising edge
                st_next.pins.ce_n = 1'b1;
                st_next.cnt       = 5'h00;
                st_next.phase     = PH_REC;
            end
            PH_READ: begin
                // Sample once access time has passed
                if (st_reg.cnt == ACC_CYC - 5'h01) begin
                    // Upper byte is not on the bus in byte mode
                    st_next.rdata     = st_reg.byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
                    st_next.pins.oe_n = 1'b1;
                    st_next.pins.ce_n = 1'b1;
                    st_next.cnt       = 5'h00;
                    st_next.phase     = PH_REC;
                end else begin
                    st_next.cnt = st_reg.cnt + 5'h01;
                end
            end
            PH_REC: begin
                st_next.dq_oe = 1'b0;
                if (st_reg.cnt == REC_CYC - 5'h01) begin
                    st_next.phase = PH_IDLE;
                    st_next.done  = 1'b1;
                    st_next.match = 1'b0;
                    case (st_reg.op)
                        OP_ENTER: begin
                            // Remember where query was entered from
                            st_next.mode = st_reg.from_id ? MODE_QRY_ID : MODE_QRY_ARR;
                        end
                        OP_EXIT: begin
                            // Return to the entry mode
                            st_next.mode = (st_reg.mode == MODE_QRY_ID) ? MODE_ID
                                                                       : MODE_ARRAY;
                        end
                        default: begin
                            // Compare with the known table
                            st_next.match = (st_reg.rdata == expect_word);
                        end
                    endcase
                end else begin
                    st_next.cnt = st_reg.cnt + 5'h01;
                end
            end
            default: begin
                st_next = ST_RESET;
            end
        endcase
        st_next.ready = (st_next.phase == PH_IDLE);
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    // Reset loads constants only
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    assign ready_out   = st_reg.ready;
    assign done_out    = st_reg.done;
    assign refused_out = st_reg.refused;
    assign rdata_out   = st_reg.rdata;
    assign match_out   = st_reg.match;
    assign mode_out    = st_reg.mode;
    assign pins_out    = st_reg.pins;
    assign dq_data_out = st_reg.dq_data;
    assign dq_oe_out   = st_reg.dq_oe;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    AST_QRY_WORD: assert property (
        (st_reg.phase == PH_STROBE && st_reg.op == OP_ENTER && !st_reg.byte_mode)
        |-> (st_reg.pins.addr == QRY_ADDR_WORD && st_reg.dq_data[7:0] == QUERY_CODE)
    ) else $error("query write in word mode has wrong address or code");

    AST_QRY_BYTE: assert property (
        (st_reg.phase == PH_STROBE && st_reg.op == OP_ENTER && st_reg.byte_mode)
        |-> (st_reg.pins.addr == QRY_ADDR_BYTE && st_reg.dq_data[7:0] == QUERY_CODE)
    ) else $error("query write in byte mode has wrong address or code");

    AST_EXIT_ARRAY: assert property (
        (st_reg.phase == PH_REC && st_reg.op == OP_EXIT && st_reg.mode == MODE_QRY_ARR
         && st_reg.cnt == REC_CYC - 5'h01) |=> (st_reg.mode == MODE_ARRAY && st_reg.done)
    ) else $error("reset did not return to array read");

    AST_NO_BUSY_ENTRY: assert property (
        (st_reg.phase == PH_IDLE && cmd_valid_in && cmd_op_in == OP_ENTER && !dev_ready_in)
        |=> (st_reg.refused && st_reg.phase == PH_IDLE && st_reg.pins.ce_n)
    ) else $error("query entry started while device busy");

    AST_ENTER_FROM_ID: assert property (
        (st_reg.phase == PH_REC && st_reg.op == OP_ENTER && st_reg.from_id
         && st_reg.cnt == REC_CYC - 5'h01) |=> (st_reg.mode == MODE_QRY_ID)
    ) else $error("entry from ID mode not remembered");

    AST_EXIT_ID: assert property (
        (st_reg.phase == PH_REC && st_reg.op == OP_EXIT && st_reg.mode == MODE_QRY_ID
         && st_reg.cnt == REC_CYC - 5'h01) |=> (st_reg.mode == MODE_ID)
    ) else $error("reset did not return to ID mode");

    AST_READ_TIME: assert property (
        (st_reg.phase == PH_IDLE && cmd_valid_in && cmd_op_in == OP_READ && query_now)
        |-> ##20 (st_reg.done && st_reg.pins.oe_n)
    ) else $error("table read did not finish on time");

    AST_BYTE_ADDR: assert property (
        (st_reg.phase == PH_READ && st_reg.byte_mode)
        |-> (st_reg.pins.addr == {13'h0000, st_reg.idx, 1'b0})
    ) else $error("byte mode read not at doubled address");

    AST_WE_WIDTH: assert property (
        $fell(st_reg.pins.we_n) |-> (!st_reg.pins.we_n)[*7] ##1 st_reg.pins.we_n
    ) else $error("write strobe width wrong");

    AST_DATA_HOLD: assert property (
        $rose(st_reg.pins.we_n) |-> (st_reg.dq_oe && !st_reg.pins.ce_n && st_reg.pins.oe_n)
    ) else $error("data not held past write strobe");

endmodule // qry_host

// *** verification/flash_qry_model.sv ***
/*
 * Behavioural parallel flash that answers the query-table host.
 * Assumes the bench resolves the data bus and sets the bank busy level.
 */
`timescale 1ns/100ps
module flash_qry_model (
    // Host strobes and bus
    input  wire qry_host_pkg::flash_pins_t pins_in,
    input  wire logic [15:0]               dq_in,
    input  wire logic                      byte_in,
    // Bench controls
    input  wire logic                      busy_in,
    input  wire logic                      slow_in,
    input  wire logic                      bad_in,
    // Device data drive
    output logic      [15:0]               dq_out
);
    import qry_host_pkg::*;
    // Low bytes of words 10h..34h, upper bytes all zero
    localparam logic [295:0] TBL = 296'h51525902_00400000_00000027_36000004_000A0005_00040016_02000000_02070020_003E0000_01;
    logic [21:0] addr_q;      // Latched write address
    logic        qry_q = 0;   // Query mode active
    logic        ok_q = 0;    // Read data settled
    logic [15:0] last_q = 0;  // Last value shown
    logic [15:0] word;        // Word at read address
    logic [7:0]  idx;         // Word index
    wire         wr = ~pins_in.ce_n & ~pins_in.we_n;
    wire         rd = ~pins_in.ce_n & ~pins_in.oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Address at the later falling strobe
    always @(posedge wr) begin
        addr_q = pins_in.addr;
    end
    // Data at the earlier rising strobe; busy bank ignores the query code
    always @(negedge wr) begin
        if (dq_in[7:0] == QUERY_CODE && !busy_in && !qry_q &&
            addr_q == (byte_in ? QRY_ADDR_BYTE : QRY_ADDR_WORD)) begin
            qry_q = 1'b1;
        end else if (dq_in[7:0] == 8'hF0) begin
            qry_q = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access time: prompt, or close to the host's sampling point
    always @(negedge pins_in.oe_n) begin
        ok_q = 1'b0;
        #(slow_in ? 60 : 10);
        ok_q = 1'b1;
    end
    always @(posedge pins_in.oe_n) begin
        ok_q = 1'b0;
    end
    always @(posedge ok_q) begin
        last_q = word;
    end
    // Released bus shows the inverse of the last value, never a stale copy
    always @* begin
        idx = byte_in ? pins_in.addr[8:1] : pins_in.addr[7:0];
        word = 16'h0000;
        if (!qry_q) begin
            word = 16'hFFFF;
        end else if ((pins_in.addr >> (byte_in ? 9 : 8)) == 0 && idx >= 8'h10 &&
                     idx <= 8'h34 && !(byte_in && pins_in.addr[0])) begin
            word = {8'h00, TBL[295 - 8 * (int'(idx) - 16) -: 8]};
        end
        if (bad_in) begin
            word = word ^ 16'h0001;
        end
        if (byte_in) begin
            word[15:8] = 8'h5A; // Upper lines unused in byte mode
        end
        dq_out = (rd && ok_q) ? word : ~last_q;
    end
endmodule // flash_qry_model

// *** verification/tb_qry_host.sv ***
/*
 * Self-checking bench for the query-table host controller.
 * Assumes the flash model on the far side and the package constants.
 */
`timescale 1ns/100ps
module tb_qry_host;
    import qry_host_pkg::*;
    localparam logic [295:0] TBL = 296'h51525902_00400000_00000027_36000004_000A0005_00040016_02000000_02070020_003E0000_01;
    logic        clk_in, nrst_in, cmd_valid_in, byte_mode_in, id_mode_in, dev_ready_in;
    logic        ready_out, done_out, refused_out, match_out, dq_oe_out, slow, bad;
    op_t         cmd_op_in;
    logic [7:0]  index_in;
    logic [15:0] rdata_out, dq_data_out, dev_dq, dq_wire;
    mode_t       mode_out, mode_e;
    flash_pins_t pins_out;
    int          num_errors = 0, total_checks = 0, cycles = 0;

    // Host drives the bus only while enabled
    assign dq_wire = dq_oe_out ? dq_data_out : dev_dq;

    qry_host i_qry_host (.clk_in(clk_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid_in),
        .cmd_op_in(cmd_op_in), .index_in(index_in), .byte_mode_in(byte_mode_in),
        .id_mode_in(id_mode_in), .ready_out(ready_out), .done_out(done_out),
        .refused_out(refused_out), .rdata_out(rdata_out), .match_out(match_out),
        .mode_out(mode_out), .dev_ready_in(dev_ready_in), .dq_in(dq_wire),
        .pins_out(pins_out), .dq_data_out(dq_data_out), .dq_oe_out(dq_oe_out));
    flash_qry_model i_flash_qry_model (.pins_in(pins_out), .dq_in(dq_wire),
        .byte_in(byte_mode_in), .busy_in(!dev_ready_in), .slow_in(slow), .bad_in(bad),
        .dq_out(dev_dq));

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One request, checked against the reference model of mode and table
    task automatic do_cmd(input op_t op, input logic [7:0] idx);
        int          n;
        logic        ref_e;
        logic [15:0] w_e;
        ref_e = (op == OP_ENTER && (!dev_ready_in || mode_e >= MODE_QRY_ARR)) ||
                (op == OP_READ && mode_e < MODE_QRY_ARR);
        w_e = (idx >= 8'h10 && idx <= 8'h34) ? {8'h00, TBL[295 - 8 * (int'(idx) - 16) -: 8]}
                                            : 16'h0000;
        w_e = bad ? w_e ^ 16'h0001 : w_e;
        cmd_op_in = op;
        index_in = idx;
        cmd_valid_in = 1'b1;
        @(posedge clk_in);
        #1;
        cmd_valid_in = 1'b0;
        n = 1;
        while (done_out !== 1'b1 && refused_out !== 1'b1 && n < 40) begin
            @(posedge clk_in);
            #1;
            n++;
            if (n == 5) check(ready_out, 1'b0);
        end
        check(refused_out, ref_e);
        // Write: setup, 7 strobe, 1 hold, 4 recovery, done on the next edge
        check(n, ref_e ? 1 : (op == OP_READ ? 20 : 14));
        if (!ref_e) begin
            if (op == OP_ENTER) mode_e = id_mode_in ? MODE_QRY_ID : MODE_QRY_ARR;
            if (op == OP_EXIT) mode_e = (mode_e == MODE_QRY_ID) ? MODE_ID : MODE_ARRAY;
            check(match_out, op == OP_READ && !bad);
            if (op == OP_READ) check(rdata_out, w_e);
        end
        check(mode_out, mode_e);
        check(ready_out, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // Hang guard, well above the expected 4622 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles >= 20000) begin
            num_errors++;
            complete_run();
        end
    end
    // Main sequence: four sessions over word/byte, prompt/slow, array/ID
    initial begin
        {nrst_in, cmd_valid_in, byte_mode_in, id_mode_in, slow, bad} = '0;
        dev_ready_in = 1'b1;
        cmd_op_in = OP_READ;
        index_in = 8'h00;
        mode_e = MODE_ARRAY;
        void'($urandom(32'hD91898AF));
        repeat (2) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        check({pins_out.ce_n, pins_out.we_n, pins_out.oe_n, dq_oe_out}, 4'hE);
        check(mode_out, MODE_ARRAY);
        do_cmd(OP_READ, 8'h10);
        do_cmd(OP_EXIT, 8'h00);
        dev_ready_in = 1'b0;
        do_cmd(OP_ENTER, 8'h00);
        dev_ready_in = 1'b1;
        for (int s = 0; s < 4; s++) begin
            byte_mode_in = s[0];
            slow = s[1];
            id_mode_in = s[1];
            @(posedge clk_in);
            #1;
            mode_e = id_mode_in ? MODE_ID : MODE_ARRAY;
            do_cmd(OP_ENTER, 8'h00);
            do_cmd(OP_ENTER, 8'h00);
            for (int i = 8'h0F; i <= 8'h3D; i++) do_cmd(OP_READ, 8'(i));
            bad = 1'b1;
            do_cmd(OP_READ, 8'h2C);
            bad = 1'b0;
            repeat (8) do_cmd(OP_READ, 8'($urandom));
            do_cmd(OP_EXIT, 8'h00);
            do_cmd(OP_READ, 8'h10);
        end
        complete_run();
    end
endmodule // tb_qry_host
